// File: include/abrm_pkg.sv
// Package with constants and carrier types for the access bank remap block
//
// Overview of operation
// (RQ1) Lower access bank is remapped only while the extended set is on; otherwise 00h-7Fh is Bank 0.
// (RQ2) In indexed literal offset mode access offsets 00h-5Fh map to pointer two through pointer two plus 95.
// (RQ3) Only the indexed literal offset operand form is remapped; all other forms see the normal map.
// (RQ4) With the access bit set the address is the bank select register joined to the operand.
// (RQ5) Explicit indirect operands, including those on pointer two, pass through unchanged.
// (RQ6) Access operands above 05Fh use the normal access bank map even in indexed mode.
// (RQ7) Bank select behaviour for direct addressing is the same with the extended set on or off.
// (RQ8) Window address is the full pointer plus the zero-extended offset, cut to address width.
package abrm_pkg;

   localparam int ADDR_W     = 12;
   localparam int OPND_W     = 8;
   localparam int BANK_W     = 4;

   // Access bank boundaries
   localparam logic [7:0] WIN_LAST_OFS   = 8'h5f;
   localparam logic [7:0] ACC_SPLIT      = 8'h80;
   localparam logic [BANK_W-1:0] SFR_BANK = 4'hf;
   localparam logic [BANK_W-1:0] LOW_BANK = 4'h0;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_BANK   = 8'h04;
   localparam logic [7:0] OFS_PTR2   = 8'h08;
   localparam logic [7:0] OFS_STAT   = 8'h0c;

   // Control register field positions
   localparam int CTRL_EXT_BIT = 0;

   // Reset values
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
   localparam logic [ADDR_W-1:0] PTR2_RST = 12'h000;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Operand forms from the decoder
   typedef enum logic [1:0] {
      ABRM_FORM_DIRECT  = 2'h0,
      ABRM_FORM_INDEXED = 2'h1,
      ABRM_FORM_INDIR   = 2'h2
   } abrm_form_t;

   // Which mapping produced the address
   typedef enum logic [3:0] {
      ABRM_MAP_LOW    = 4'h1,
      ABRM_MAP_SFR    = 4'h2,
      ABRM_MAP_BANKED = 4'h4,
      ABRM_MAP_WINDOW = 4'h8
   } abrm_map_t;

   // Operand request from the decoder
   typedef struct packed {
      logic                  valid;
      abrm_form_t            form;
      logic                  access_bit;
      logic [OPND_W-1:0]     operand;
      logic [ADDR_W-1:0]     indir_addr;
   } abrm_req_t;

   // Resolved data memory address
   typedef struct packed {
      logic                  valid;
      abrm_map_t             map;
      logic [ADDR_W-1:0]     addr;
   } abrm_rsp_t;

endpackage

// File: rtl/abrm_map.sv
// Combinational address mapper for access bank operands
`timescale 1ns/1ps
module abrm_map (
   // Operand in
   input  wire abrm_pkg::abrm_req_t           req,
   // Mapping state
   input  wire logic                          ext_on,
   input  wire logic [abrm_pkg::BANK_W-1:0]   bank_sel,
   input  wire logic [abrm_pkg::ADDR_W-1:0]   ptr_two,
   // Result
   output abrm_pkg::abrm_rsp_t                rsp
);

   // Operand class decode
   wire in_window  = req.operand <= abrm_pkg::WIN_LAST_OFS;
   wire low_half   = req.operand < abrm_pkg::ACC_SPLIT;
   wire use_window = ext_on && req.form == abrm_pkg::ABRM_FORM_INDEXED
                     && !req.access_bit && in_window; // RQ1 RQ3 RQ6
   wire is_indir   = req.form == abrm_pkg::ABRM_FORM_INDIR;

   // Candidate addresses
   wire [abrm_pkg::ADDR_W-1:0] win_addr =
      abrm_pkg::ADDR_W'(ptr_two + {{(abrm_pkg::ADDR_W-abrm_pkg::OPND_W){1'b0}}, req.operand}); // RQ8
   wire [abrm_pkg::ADDR_W-1:0] bank_addr = {bank_sel, req.operand}; // RQ4 RQ7
   wire [abrm_pkg::ADDR_W-1:0] acc_addr  =
      {low_half ? abrm_pkg::LOW_BANK : abrm_pkg::SFR_BANK, req.operand}; // RQ1 RQ6

   // Selection
   assign rsp.valid = req.valid;
   assign rsp.addr  = is_indir       ? req.indir_addr :  // RQ5
                      req.access_bit ? bank_addr :        // RQ4
                      use_window     ? win_addr  :        // RQ2
                                       acc_addr;          // RQ3
   assign rsp.map   = (is_indir || req.access_bit) ? abrm_pkg::ABRM_MAP_BANKED :
                      use_window ? abrm_pkg::ABRM_MAP_WINDOW :
                      low_half   ? abrm_pkg::ABRM_MAP_LOW : abrm_pkg::ABRM_MAP_SFR;

endmodule

// File: rtl/abrm_top.sv
// Access bank remap block with AXI4-Lite control registers
`timescale 1ns/1ps
module abrm_top (
   // Clock and reset
   input  wire logic                        SYS_CLK,
   input  wire logic                        NRST,
   // Operand request from decoder
   input  wire abrm_pkg::abrm_req_t         REQ,
   // Resolved address to data memory
   output abrm_pkg::abrm_rsp_t              RSP,
   // AXI4-Lite write address
   input  wire logic                        AWVALID,
   output logic                             AWREADY,
   input  wire logic [7:0]                  AWADDR,
   // AXI4-Lite write data
   input  wire logic                        WVALID,
   output logic                             WREADY,
   input  wire logic [31:0]                 WDATA,
   input  wire logic [3:0]                  WSTRB,
   // AXI4-Lite write response
   output logic                             BVALID,
   input  wire logic                        BREADY,
   output logic [1:0]                       BRESP,
   // AXI4-Lite read address
   input  wire logic                        ARVALID,
   output logic                             ARREADY,
   input  wire logic [7:0]                  ARADDR,
   // AXI4-Lite read data
   output logic                             RVALID,
   input  wire logic                        RREADY,
   output logic [31:0]                      RDATA,
   output logic [1:0]                       RRESP
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   // Mapping state is written only over the bus; the status pair records
   // the last valid mapping so software can see what the mapper chose.
   // Nothing here is cleared by the mapper itself.
   logic                              ext_r;
   logic [abrm_pkg::BANK_W-1:0]       bank_r;
   logic [abrm_pkg::ADDR_W-1:0]       ptr2_r;
   abrm_pkg::abrm_map_t               last_map_r;
   logic [abrm_pkg::ADDR_W-1:0]       last_addr_r;
   abrm_pkg::abrm_rsp_t               rsp_r;
   logic                              aw_got_r;
   logic                              w_got_r;
   logic [7:0]                        aw_addr_r;
   logic [31:0]                       w_data_r;
   logic [3:0]                        w_strb_r;
   abrm_pkg::abrm_rsp_t               map_out;

   ////////////////////////////////////////////////////////////////////////////
   // Address mapper
   // Purely combinational; its result is registered below so that every
   // output toward the data memory leaves a flip-flop.
   // Bus writes reach it only through the control registers.
   abrm_map u_map (
      .req      (REQ),
      .ext_on   (ext_r),
      .bank_sel (bank_r),
      .ptr_two  (ptr2_r),
      .rsp      (map_out)
   );

   // Registered result toward the data memory
   // The valid bit follows the request; status only tracks valid beats
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         rsp_r       <= '0;
         last_map_r  <= abrm_pkg::ABRM_MAP_LOW;
         last_addr_r <= '0;
      end else begin
         rsp_r <= map_out; // RQ2
         if (map_out.valid) begin
            last_map_r  <= map_out.map;
            last_addr_r <= map_out.addr;
         end
      end
   end
   // Result leaves the block from the register
   assign RSP = rsp_r;

   ////////////////////////////////////////////////////////////////////////////
   // Write channel capture, address and data in either order
   // Each half waits in its own flag until the other arrives; the register
   // update and the response then happen together, so a late data beat
   // never pairs with a stale address.
   // Both readies stay low until the response is taken: one write at a time.
   wire aw_take  = AWVALID && AWREADY;
   wire w_take   = WVALID && WREADY;
   wire b_take   = BVALID && BREADY;
   wire wr_fire  = aw_got_r && w_got_r && !BVALID;
   wire wr_ctrl  = aw_addr_r == abrm_pkg::OFS_CTRL;
   wire wr_bank  = aw_addr_r == abrm_pkg::OFS_BANK;
   wire wr_ptr2  = aw_addr_r == abrm_pkg::OFS_PTR2;
   wire wr_stat  = aw_addr_r == abrm_pkg::OFS_STAT;
   wire wr_hit   = wr_ctrl || wr_bank || wr_ptr2 || wr_stat;
   wire [31:0] ptr_word = {20'h00000, 12'(ptr2_r)};
   wire [31:0] ptr_new;

   // Byte lane merge for the pointer; lanes without a strobe keep old bits
   genvar lane;
   generate
      for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
         assign ptr_new[8*lane +: 8] = w_strb_r[lane] ? w_data_r[8*lane +: 8] :
                                                        ptr_word[8*lane +: 8];
      end
   endgenerate

   // Write address side; ready comes back only after the response is taken
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         aw_got_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         AWREADY   <= 1'b1;
      end else begin
         if (aw_take) begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= AWADDR;
            AWREADY   <= 1'b0;
         end
         if (wr_fire)
            aw_got_r <= 1'b0;
         if (b_take)
            AWREADY <= 1'b1;
      end
   end

   // Write data side; data and strobes stay frozen until the update
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         w_got_r  <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         WREADY   <= 1'b1;
      end else begin
         if (w_take) begin
            w_got_r  <= 1'b1;
            w_data_r <= WDATA;
            w_strb_r <= WSTRB;
            WREADY   <= 1'b0;
         end
         if (wr_fire)
            w_got_r <= 1'b0;
         if (b_take)
            WREADY <= 1'b1;
      end
   end

   // Write response; unmapped offsets answer with a slave error
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         BVALID <= 1'b0;
         BRESP  <= abrm_pkg::RESP_OKAY;
      end else begin
         if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP  <= wr_hit ? abrm_pkg::RESP_OKAY : abrm_pkg::RESP_SLVERR;
         end
         if (b_take)
            BVALID <= 1'b0;
      end
   end

   // Control registers steering the mapper
   // Updates land on the edge that raises the response, after both halves
   // Control and bank need lane 0; the pointer merges lane by lane
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         ext_r  <= abrm_pkg::CTRL_RST[abrm_pkg::CTRL_EXT_BIT];
         bank_r <= abrm_pkg::BANK_RST;
         ptr2_r <= abrm_pkg::PTR2_RST;
      end else if (wr_fire) begin
         if (wr_ctrl && w_strb_r[0])
            ext_r <= w_data_r[abrm_pkg::CTRL_EXT_BIT]; // RQ1
         if (wr_bank && w_strb_r[0])
            bank_r <= w_data_r[abrm_pkg::BANK_W-1:0]; // RQ7
         if (wr_ptr2)
            ptr2_r <= ptr_new[abrm_pkg::ADDR_W-1:0]; // RQ8
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel
   // The address decodes straight off the bus; the word is latched at the
   // handshake so a write in flight cannot change data already offered.
   // Unmapped offsets read as zero with a slave error.
   // Status is read-only; writes to it are accepted and dropped.
   wire rd_ctrl = ARADDR == abrm_pkg::OFS_CTRL;
   wire rd_bank = ARADDR == abrm_pkg::OFS_BANK;
   wire rd_ptr2 = ARADDR == abrm_pkg::OFS_PTR2;
   wire rd_stat = ARADDR == abrm_pkg::OFS_STAT;
   wire rd_hit  = rd_ctrl || rd_bank || rd_ptr2 || rd_stat;
   wire [31:0] stat_word = {12'h000, 4'(last_map_r), 4'h0, last_addr_r};
   wire [31:0] rd_word   = rd_ctrl ? {31'h0000_0000, ext_r} :
                           rd_bank ? {28'h000_0000, bank_r} :
                           rd_ptr2 ? ptr_word :
                           rd_stat ? stat_word : 32'h0000_0000;

   // Read handshake; ready returns the cycle after the data is taken
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         ARREADY <= 1'b1;
         RVALID  <= 1'b0;
         RDATA   <= 32'h0000_0000;
         RRESP   <= abrm_pkg::RESP_OKAY;
      end else begin
         if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RDATA   <= rd_word;
            RRESP   <= rd_hit ? abrm_pkg::RESP_OKAY : abrm_pkg::RESP_SLVERR;
         end
         if (RVALID && RREADY) begin
            RVALID  <= 1'b0;
            ARREADY <= 1'b1;
         end
      end
   end

endmodule

// File: dv/abrm_dec_model.sv
// Decoder model that issues operand requests to the remap block
`timescale 1ns/1ps
module abrm_dec_model (
   // Clock
   input wire logic            SYS_CLK,
   // Request toward the block
   output abrm_pkg::abrm_req_t req
);
   initial req = '0;
   // One request for one cycle; after it valid drops and the fields other than the form are inverted, not held
   task automatic issue(input abrm_pkg::abrm_form_t f, input logic a,
                        input logic [7:0] op, input logic [11:0] ia);
      @(posedge SYS_CLK);
      req <= '{1'b1, f, a, op, ia};
      @(posedge SYS_CLK);
      req <= '{1'b0, f, ~a, ~op, ~ia};
   endtask
endmodule

// File: dv/abrm_monitor.sv
// Port checker for the access bank remap block
`timescale 1ns/1ps
module abrm_monitor (
   input wire logic                SYS_CLK,
   input wire logic                NRST,
   input wire abrm_pkg::abrm_req_t REQ,
   input wire abrm_pkg::abrm_rsp_t RSP
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);
   // Request classes as the mapper sees them, except that win ignores the extended set enable
   wire ind = REQ.valid && REQ.form == abrm_pkg::ABRM_FORM_INDIR;
   wire bnk = REQ.valid && !ind && REQ.access_bit;
   wire acc = REQ.valid && !ind && !REQ.access_bit;
   wire win = acc && REQ.form == abrm_pkg::ABRM_FORM_INDEXED && REQ.operand <= 8'h5f;
   ////////////////////////////////////////////////////////////////////////////
   chk_answer_next: assert property (REQ.valid |=> RSP.valid)
      else $error("Request got no answer");
   chk_indir_pass: assert property (ind |=> RSP.addr == $past(REQ.indir_addr))
      else $error("Indirect address altered");
   chk_bank_join: assert property (bnk |=> RSP.addr[7:0] == $past(REQ.operand)
      && RSP.map == abrm_pkg::ABRM_MAP_BANKED) else $error("Banked address wrong");
   chk_upper_plain: assert property (acc && REQ.operand > 8'h5f
      |=> RSP.addr == {{4{$past(REQ.operand[7])}}, $past(REQ.operand)})
      else $error("Upper access map wrong");
   chk_direct_plain: assert property (acc && REQ.form == abrm_pkg::ABRM_FORM_DIRECT
      |=> RSP.addr == {{4{$past(REQ.operand[7])}}, $past(REQ.operand)})
      else $error("Direct access remapped");
   chk_window_cause: assert property (RSP.valid && RSP.map == abrm_pkg::ABRM_MAP_WINDOW
      |-> $past(win)) else $error("Window without cause");
   chk_low_bank: assert property (RSP.valid && RSP.map == abrm_pkg::ABRM_MAP_LOW
      |-> RSP.addr[11:7] == 5'h00) else $error("Low map outside bank 0");
   chk_sfr_bank: assert property (RSP.valid && RSP.map == abrm_pkg::ABRM_MAP_SFR
      |-> RSP.addr[11:7] == 5'h1f) else $error("Upper map outside bank F");
   // Main scenarios
   cov_window: cover property (win ##1 RSP.valid);
   cov_indir: cover property (ind ##1 RSP.valid);
   cov_bank: cover property (bnk ##1 RSP.valid);
endmodule
bind abrm_top abrm_monitor u_mon (.SYS_CLK(SYS_CLK), .NRST(NRST), .REQ(REQ), .RSP(RSP));

// File: dv/testbench.sv
// Self-checking testbench for the access bank remap block
`timescale 1ns/1ps
module testbench;
   logic                sys_clk = 1'b0;
   logic                nrst = 1'b0;
   logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic                arvalid = 1'b0, rready = 1'b0;
   logic [7:0]          awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]         wdata = 32'h0;
   logic [3:0]          wstrb = 4'hf, strb_sel = 4'hf;
   wire                 awready, wready, bvalid, arready, rvalid;
   wire [1:0]           bresp, rresp;
   wire [31:0]          rdata;
   abrm_pkg::abrm_req_t req;
   abrm_pkg::abrm_rsp_t rsp;
   int                  bad_count = 0, cmp_count = 0;
   localparam abrm_pkg::abrm_form_t f_dir = abrm_pkg::ABRM_FORM_DIRECT;
   localparam abrm_pkg::abrm_form_t f_idx = abrm_pkg::ABRM_FORM_INDEXED;
   localparam abrm_pkg::abrm_form_t f_ind = abrm_pkg::ABRM_FORM_INDIR;
   always #10 sys_clk = ~sys_clk;
   abrm_dec_model dec (.SYS_CLK(sys_clk), .req(req));
   abrm_top dut (.SYS_CLK(sys_clk), .NRST(nrst), .REQ(req), .RSP(rsp),
      .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid),
      .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready),
      .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
      .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp));
   ////////////////////////////////////////////////////////////////////////////
   // Verdict and comparisons
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk_addr(input logic [12:0] got, input logic [12:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t address %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [33:0] got, input logic [33:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t bus data/resp %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tmo;
      bad_count++;
      $display("[FAIL] %0t bus wait ran out", $time);
      end_of_test;
   endtask
   // Bus write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      @(posedge sys_clk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= v;
      wstrb <= strb_sel;
      bready <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 20) tmo;
      chk_reg({32'h0, bresp}, {32'h0, er});
   endtask
   // Bus read: data and response taken at the edge where the answer is seen
   task automatic rd(input logic [7:0] a, input logic [33:0] exp);
      int n;
      @(posedge sys_clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (n == 20) tmo;
      chk_reg({rdata, rresp}, exp);
   endtask
   // One operand request and its mapped address one cycle later
   task automatic mp(input abrm_pkg::abrm_form_t f, input logic a, input logic [7:0] op,
                     input logic [11:0] ia, input logic [11:0] exp);
      dec.issue(f, a, op, ia);
      #1;
      chk_addr({rsp.valid, rsp.addr}, {1'b1, exp});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(8'h00, 34'h0);
      rd(8'h08, 34'h0);
      rd(8'h10, {32'h0, 2'h2});
      wr(8'h10, 32'h1, 2'h2);
      mp(f_idx, 1'b0, 8'h10, 12'h000, 12'h010);
      mp(f_idx, 1'b0, 8'h90, 12'h000, 12'hf90);
      wr(8'h04, 32'h5, 2'h0);
      mp(f_dir, 1'b1, 8'h22, 12'h000, 12'h522);
      wr(8'h08, 32'hfc0, 2'h0);
      wr(8'h00, 32'h1, 2'h0);
      rd(8'h08, {32'hfc0, 2'h0});
      mp(f_idx, 1'b0, 8'h00, 12'h000, 12'hfc0);
      rd(8'h0c, {32'h0008_0fc0, 2'h0});
      mp(f_idx, 1'b0, 8'h5f, 12'h000, 12'h01f);
      mp(f_idx, 1'b0, 8'h60, 12'h000, 12'h060);
      mp(f_idx, 1'b0, 8'hf0, 12'h000, 12'hff0);
      mp(f_dir, 1'b0, 8'h10, 12'h000, 12'h010);
      mp(f_idx, 1'b1, 8'h22, 12'h000, 12'h522);
      mp(f_ind, 1'b0, 8'h10, 12'hfc0, 12'hfc0);
      mp(f_ind, 1'b1, 8'h33, 12'habc, 12'habc);
      wr(8'h00, 32'h0, 2'h0);
      mp(f_idx, 1'b0, 8'h10, 12'h000, 12'h010);
      rd(8'h0c, {32'h0001_0010, 2'h0});
      // Partial strobes: pointer merges per lane, control and bank need lane 0
      strb_sel = 4'h2;
      wr(8'h08, 32'h0000_0a55, 2'h0);
      rd(8'h08, {32'h0000_0ac0, 2'h0});
      wr(8'h00, 32'h1, 2'h0);
      rd(8'h00, 34'h0);
      wr(8'h04, 32'h7, 2'h0);
      rd(8'h04, {32'h5, 2'h0});
      end_of_test;
   end
endmodule
